// ---- aes_regs.svh ----
// register map, field positions and timing counts of the aes engine
`ifndef AES_REGS_SVH
`define AES_REGS_SVH

// register indices; byte address is four times the index
`define AES_IDX_CTRL    3'h0
`define AES_IDX_STATUS  3'h1
`define AES_IDX_STATE   3'h2
`define AES_IDX_KEY     3'h3
`define AES_IDX_INTCTRL 3'h4

`define AES_CTRL_START  7
`define AES_CTRL_AUTO   6
`define AES_CTRL_RESET  5
`define AES_CTRL_DECRYPT 4
`define AES_CTRL_XOR    2
`define AES_STAT_ERROR  7
`define AES_STAT_DONE   0

`define AES_RST_BYTE    8'h00
`define AES_RST_PTR     4'h0

// last cycle of a run and the last round step
`define AES_LAST_CYC    9'h176
`define AES_LAST_STEP   9'h00a

`endif

// ---- aes_pkg.sv ----
// types shared by the aes engine
package aes_pkg;
  typedef enum logic [1:0] {
    AES_IDLE = 2'b01,
    AES_RUN  = 2'b10
  } aes_state_e;
endpackage

// ---- aes_engine.sv ----
// aes-128 engine with byte-wide apb register port
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "aes_regs.svh"
module aes_engine
  import aes_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [AW-1:0] paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               irq,
  output logic      [1:0]    irq_priority_level,
  output logic               dma_trigger
);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // arithmetic helpers
  // ****************************************************************
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
  endfunction
  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction
  // x^254 is the field inverse; zero maps to zero
  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] r;
    logic [7:0] y;
    r = 8'h01;
    y = x;
    for (int i = 0; i < 7; i++) begin
      y = gmul(y, y);
      r = gmul(r, y);
    end
    return r;
  endfunction
  function automatic logic [7:0] rl(input logic [7:0] x, input int n);
    logic [15:0] d;
    d = {x, x} << n;
    return d[15:8];
  endfunction
  // s-box computed rather than tabled: smaller source, deeper logic
  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] b;
    b = ginv(x);
    return b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
  endfunction
  function automatic logic [7:0] isbox(input logic [7:0] y);
    return ginv(rl(y, 1) ^ rl(y, 3) ^ rl(y, 6) ^ 8'h05);
  endfunction
  // byte i of a block sits at bits [8i +: 8]; row r, column c is r+4c
  function automatic logic [127:0] sub_shift(input logic [127:0] s,
                                             input logic inv);
    logic [127:0] o;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        if (inv)
          o[8*(r+4*((c+r)%4)) +: 8] = isbox(s[8*(r+4*c) +: 8]);
        else
          o[8*(r+4*c) +: 8] = sbox(s[8*(r+4*((c+r)%4)) +: 8]);
      end
    end
    return o;
  endfunction
  function automatic logic [127:0] mix(input logic [127:0] s,
                                       input logic inv);
    logic [127:0] o;
    logic [7:0]   co [4];
    logic [7:0]   b;
    o = '0;
    co[0] = inv ? 8'h0e : 8'h02;
    co[1] = inv ? 8'h0b : 8'h03;
    co[2] = inv ? 8'h0d : 8'h01;
    co[3] = inv ? 8'h09 : 8'h01;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        b = 8'h00;
        for (int k = 0; k < 4; k++)
          b = b ^ gmul(s[8*(((r+k)%4)+4*c) +: 8], co[k]);
        o[8*(r+4*c) +: 8] = b;
      end
    end
    return o;
  endfunction
  function automatic logic [7:0] rcon(input logic [3:0] rnd);
    logic [7:0] c;
    c = 8'h01;
    for (int i = 1; i < 10; i++) begin
      if (4'(i) < rnd) c = xt(c);
    end
    return c;
  endfunction
  function automatic logic [31:0] subrot(input logic [31:0] w,
                                         input logic [7:0] rc);
    return {sbox(w[7:0]), sbox(w[31:24]), sbox(w[23:16]),
            sbox(w[15:8]) ^ rc};
  endfunction
  // one step of the key schedule, forwards or backwards
  function automatic logic [127:0] kstep(input logic [127:0] k,
                                         input logic [3:0] rnd,
                                         input logic inv);
    logic [31:0] w0, w1, w2, w3;
    if (inv) begin
      w3 = k[127:96] ^ k[95:64];
      w2 = k[95:64] ^ k[63:32];
      w1 = k[63:32] ^ k[31:0];
      w0 = k[31:0] ^ subrot(w3, rcon(rnd));
    end else begin
      w0 = k[31:0] ^ subrot(k[127:96], rcon(rnd));
      w1 = k[63:32] ^ w0;
      w2 = k[95:64] ^ w1;
      w3 = k[127:96] ^ w2;
    end
    return {w3, w2, w1, w0};
  endfunction

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic [7:0]   state_mem [16];
  logic [7:0]   key_mem [16];
  logic [3:0]   st_rd_reg, st_wr_reg, key_rd_reg, key_wr_reg;
  logic [3:0]   acc_cnt_reg;
  logic [7:0]   ctrl_reg;
  logic         soft_rst_reg;
  logic         err_reg, done_reg, dma_reg;
  logic [1:0]   lvl_reg;
  logic [8:0]   cyc_reg;
  aes_state_e   fsm_reg;
  logic [31:0]  prdata_reg;
  logic         pslverr_reg;
  logic [2:0]   idx;
  logic         mapped, setup, acc, wr, rd, busy;
  logic         ctrl_acc, st_wr, st_rd, key_wr, key_rd;
  logic         go_req, start_ok, auto_go, fin;
  logic [127:0] st_v, key_v, st_n, key_n, tmp;
  logic [7:0]   wbyte;
  assign idx    = paddr[4:2];
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[AW-1:5] == '0) &&
                  (idx <= `AES_IDX_INTCTRL);
  assign setup  = psel && !penable;
  assign acc    = psel && penable && mapped;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign busy   = (fsm_reg == AES_RUN);
  assign wbyte  = pwdata[7:0];
  assign ctrl_acc = acc && (idx == `AES_IDX_CTRL);
  assign st_wr  = wr && !busy && (idx == `AES_IDX_STATE);
  assign st_rd  = rd && !busy && (idx == `AES_IDX_STATE);
  assign key_wr = wr && !busy && (idx == `AES_IDX_KEY);
  assign key_rd = rd && !busy && (idx == `AES_IDX_KEY);
  assign go_req   = wr && (idx == `AES_IDX_CTRL) &&
                    wbyte[`AES_CTRL_START] && !busy;
  assign start_ok = go_req && (acc_cnt_reg == `AES_RST_PTR);
  // 16th state write with auto set
  assign auto_go  = ctrl_reg[`AES_CTRL_AUTO] && st_wr &&
                    (st_wr_reg == 4'hf);
  assign fin      = busy && (cyc_reg == `AES_LAST_CYC);
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;
  // read data is captured in the setup cycle and held for the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      pslverr_reg <= !mapped;
      prdata_reg  <= '0;
      if (mapped && !pwrite) begin
        case (idx)
          `AES_IDX_CTRL:    prdata_reg[7:0] <= ctrl_reg;
          `AES_IDX_STATUS:  prdata_reg[7:0] <= {err_reg, 6'h00, done_reg};
          `AES_IDX_STATE:   prdata_reg[7:0] <= busy ? 8'h00
                                               : state_mem[st_rd_reg];
          `AES_IDX_KEY:     prdata_reg[7:0] <= busy ? 8'h00
                                               : key_mem[key_rd_reg];
          `AES_IDX_INTCTRL: prdata_reg[7:0] <= {6'h00, lvl_reg};
          default:          prdata_reg[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // control, status and sequencing
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= `AES_RST_BYTE;
      soft_rst_reg <= 1'b0;
      lvl_reg      <= 2'b00;
      err_reg      <= 1'b0;
      done_reg     <= 1'b0;
      dma_reg      <= 1'b0;
      fsm_reg      <= AES_IDLE;
      cyc_reg      <= '0;
    end else if (soft_rst_reg) begin
      ctrl_reg     <= `AES_RST_BYTE;
      soft_rst_reg <= 1'b0;
      lvl_reg      <= 2'b00;
      err_reg      <= 1'b0;
      done_reg     <= 1'b0;
      dma_reg      <= 1'b0;
      fsm_reg      <= AES_IDLE;
      cyc_reg      <= '0;
    end else begin
      dma_reg <= fin;
      if (wr && idx == `AES_IDX_INTCTRL) lvl_reg <= wbyte[1:0];
      if (wr && idx == `AES_IDX_CTRL) begin
        ctrl_reg[`AES_CTRL_AUTO]    <= wbyte[`AES_CTRL_AUTO];
        ctrl_reg[`AES_CTRL_DECRYPT] <= wbyte[`AES_CTRL_DECRYPT];
        ctrl_reg[`AES_CTRL_XOR]     <= wbyte[`AES_CTRL_XOR];
        ctrl_reg[`AES_CTRL_RESET]   <= wbyte[`AES_CTRL_RESET];
        soft_rst_reg                <= wbyte[`AES_CTRL_RESET];
      end
      // error flag: set wins over the write-one clear
      if ((ctrl_acc && busy) || (go_req && !start_ok))
        err_reg <= 1'b1;
      else if (wr && idx == `AES_IDX_STATUS && wbyte[`AES_STAT_ERROR])
        err_reg <= 1'b0;
      // done flag: set wins over both clears
      if (fin)
        done_reg <= 1'b1;
      else if ((st_rd && st_rd_reg == `AES_RST_PTR) ||
               (wr && idx == `AES_IDX_STATUS && wbyte[`AES_STAT_DONE]))
        done_reg <= 1'b0;
      case (fsm_reg)
        AES_IDLE: begin
          cyc_reg <= '0;
          if (start_ok || auto_go) begin
            fsm_reg                   <= AES_RUN;
            ctrl_reg[`AES_CTRL_START] <= 1'b1;
          end
        end
        AES_RUN: begin
          cyc_reg <= cyc_reg + 9'h001;
          // any control access aborts: it raises error and drops start
          if (fin || ctrl_acc) begin
            fsm_reg                   <= AES_IDLE;
            ctrl_reg[`AES_CTRL_START] <= 1'b0;
          end
        end
        default: begin
          fsm_reg                   <= AES_IDLE;
          ctrl_reg[`AES_CTRL_START] <= 1'b0;
        end
      endcase
    end
  end

  assign irq_priority_level = lvl_reg;
  assign irq                = done_reg && (lvl_reg != 2'b00);
  assign dma_trigger        = dma_reg;

  // ****************************************************************
  // pointers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_rd_reg   <= `AES_RST_PTR;
      st_wr_reg   <= `AES_RST_PTR;
      key_rd_reg  <= `AES_RST_PTR;
      key_wr_reg  <= `AES_RST_PTR;
      acc_cnt_reg <= `AES_RST_PTR;
    end else if (soft_rst_reg || ctrl_acc) begin
      st_rd_reg   <= `AES_RST_PTR;
      st_wr_reg   <= `AES_RST_PTR;
      key_rd_reg  <= `AES_RST_PTR;
      key_wr_reg  <= `AES_RST_PTR;
      acc_cnt_reg <= `AES_RST_PTR;
    end else begin
      // 4-bit pointers wrap to zero on their own
      if (st_wr) st_wr_reg <= st_wr_reg + 4'h1;
      if (st_rd || (st_wr && ctrl_reg[`AES_CTRL_XOR]))
        st_rd_reg <= st_rd_reg + 4'h1;
      if (key_wr) key_wr_reg <= key_wr_reg + 4'h1;
      if (key_rd) key_rd_reg <= key_rd_reg + 4'h1;
      if (st_wr || st_rd || key_wr || key_rd)
        acc_cnt_reg <= acc_cnt_reg + 4'h1;
    end
  end

  // ****************************************************************
  // datapath: one round step per cycle over the first eleven cycles
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      st_v[8*i +: 8]  = state_mem[i];
      key_v[8*i +: 8] = key_mem[i];
    end
    tmp   = '0;
    key_n = key_v;
    st_n  = st_v;
    if (cyc_reg == 9'h000) begin
      st_n = st_v ^ key_v;
    end else if (cyc_reg <= `AES_LAST_STEP) begin
      if (ctrl_reg[`AES_CTRL_DECRYPT]) begin
        // loaded key is round ten; walk the schedule back to round zero
        key_n = kstep(key_v, 4'(`AES_LAST_STEP - cyc_reg + 9'h001),
                      1'b1);
        tmp   = sub_shift(st_v, 1'b1) ^ key_n;
        st_n  = (cyc_reg == `AES_LAST_STEP) ? tmp : mix(tmp, 1'b1);
      end else begin
        key_n = kstep(key_v, cyc_reg[3:0], 1'b0);
        tmp   = sub_shift(st_v, 1'b0);
        st_n  = ((cyc_reg == `AES_LAST_STEP) ? tmp : mix(tmp, 1'b0))
                ^ key_n;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        state_mem[i] <= `AES_RST_BYTE;
        key_mem[i]   <= `AES_RST_BYTE;
      end
    end else if (soft_rst_reg) begin
      for (int i = 0; i < 16; i++) begin
        state_mem[i] <= `AES_RST_BYTE;
        key_mem[i]   <= `AES_RST_BYTE;
      end
    end else if (busy && cyc_reg <= `AES_LAST_STEP) begin
      for (int i = 0; i < 16; i++) begin
        state_mem[i] <= st_n[8*i +: 8];
        key_mem[i]   <= key_n[8*i +: 8];
      end
    end else begin
      if (st_wr)
        state_mem[st_wr_reg] <= ctrl_reg[`AES_CTRL_XOR]
                                ? state_mem[st_wr_reg] ^ wbyte : wbyte;
      if (key_wr) key_mem[key_wr_reg] <= wbyte;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_RUN_FROM_ZERO: assert property ($rose(busy) |-> cyc_reg == 9'h000)
    else $error("run did not start at cycle zero");
  AST_DONE_AT_END: assert property (fin && !ctrl_acc |=> done_reg && !busy &&
    !ctrl_reg[`AES_CTRL_START])
    else $error("done not set at end of run");
  AST_DMA_WITH_DONE: assert property ($rose(done_reg) |-> dma_trigger ##1
    !dma_trigger)
    else $error("dma trigger not a single pulse with done");
  AST_IRQ_ON_DONE: assert property ($rose(done_reg) && lvl_reg != 2'b00 |->
    irq)
    else $error("interrupt missing on done");
  AST_CTRL_CLR_PTR: assert property (ctrl_acc |=> st_rd_reg == 4'h0 &&
    st_wr_reg == 4'h0 && key_rd_reg == 4'h0 && key_wr_reg == 4'h0)
    else $error("pointers not cleared by control access");
  AST_SOFT_RST: assert property (soft_rst_reg |=> !soft_rst_reg &&
    ctrl_reg == 8'h00 && !busy)
    else $error("soft reset did not clear engine");
  AST_ERR_BUSY_CTRL: assert property (busy && ctrl_acc && !soft_rst_reg |=>
    err_reg && !busy)
    else $error("control access while busy not flagged");
  AST_BUSY_NO_PTR: assert property (busy && !ctrl_acc |=>
    $stable(st_wr_reg) && $stable(key_wr_reg))
    else $error("pointer moved while busy");
  AST_XOR_BOTH: assert property (st_wr && ctrl_reg[`AES_CTRL_XOR] &&
    !soft_rst_reg |=> st_rd_reg == $past(st_rd_reg) + 4'h1)
    else $error("xor write did not advance read pointer");
  AST_BAD_START: assert property (go_req && acc_cnt_reg != 4'h0 &&
    !soft_rst_reg |=> err_reg && !busy)
    else $error("bad start not flagged");

  COV_DONE: cover property (fin ##1 done_reg);
  COV_DECRYPT: cover property (fin && ctrl_reg[`AES_CTRL_DECRYPT]);
  COV_AUTO: cover property (auto_go);
  COV_ERROR: cover property ($rose(err_reg));

endmodule

// ---- aes_host.sv ----
// apb master model standing in for the cpu or dma controller
`timescale 1ns/10ps
module aes_host (
  input  wire logic        pclk,
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    paddr <= 8'h00;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h0;
  end
  // ******************************
  // bus cycles
  // ******************************
  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [2:0] idx,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {3'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait limit here: the bench timeout ends a hung access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not look like it still holds
    pwdata <= ~pwdata;
    @(posedge pclk);
  endtask
  // sixteen bytes in a row, byte 0 first, only while the engine is idle
  task automatic load(input logic [2:0] idx, input logic [127:0] v);
    logic [7:0] q;
    logic       e;
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, idx, v[127-8*i -: 8], q, e);
    end
  endtask
  task automatic fetch(input logic [2:0] idx, output logic [127:0] v);
    logic [7:0] q;
    logic       e;
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, idx, 8'h00, q, e);
      v[127-8*i -: 8] = q;
    end
  endtask
endmodule

// ---- test_aes128_crypto_engine.sv ----
// self-checking bench for the aes engine
`timescale 1ns/10ps
`include "aes_regs.svh"
module test_aes128_crypto_engine;
  localparam logic [127:0] KEY0 = 128'h000102030405060708090a0b0c0d0e0f;
  localparam logic [127:0] PT   = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] CT   = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  localparam logic [127:0] RK10 = 128'h13111d7fe3944a17f307a78b4d2b30c5;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [1:0]  lvl;
  logic        dma_trigger;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          dma_count = 0;

  aes_engine #(.AW(8)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .irq_priority_level(lvl), .dma_trigger(dma_trigger));
  aes_host host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
  end
  always #20 pclk = ~pclk;
  // the run needs about 2400 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // counted between edges, where the one-cycle pulse is settled
  always @(negedge pclk) begin
    if (dma_trigger === 1'b1) begin
      dma_count <= dma_count + 1;
    end
  end
  // ******************************
  // helpers
  // ******************************
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    host.xfer(1'b1, idx, d, q, e);
  endtask
  task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    logic       e;
    host.xfer(1'b0, idx, 8'h00, q, e);
    chk(128'(q), 128'(exp));
  endtask
  // samples between edges; returns just after a falling edge
  task automatic wait_done(output int n);
    n = 0;
    while (dma_trigger !== 1'b1 && n < 1000) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset();
    logic [7:0] q;
    logic       e;
    rd(`AES_IDX_CTRL, 8'h00);
    rd(`AES_IDX_STATUS, 8'h00);
    rd(`AES_IDX_INTCTRL, 8'h00);
    host.xfer(1'b0, 3'h5, 8'h00, q, e);
    chk(128'(e), 128'h1);
    chk(128'(pready), 128'h1);
    $display("test reset done");
  endtask
  task automatic t_encrypt();
    int           n;
    logic [127:0] v;
    wr(`AES_IDX_INTCTRL, 8'h01);
    wr(`AES_IDX_CTRL, 8'h00);
    host.load(`AES_IDX_KEY, KEY0);
    host.load(`AES_IDX_STATE, PT);
    wr(`AES_IDX_CTRL, 8'h80);
    wait_done(n);
    chk(128'(n), 128'd375);
    chk(128'(irq), 128'h1);
    chk(128'(lvl), 128'h1);
    @(negedge pclk);
    chk(128'(dma_trigger), 128'h0);
    @(posedge pclk);
    rd(`AES_IDX_STATUS, 8'h01);
    rd(`AES_IDX_CTRL, 8'h00);
    host.fetch(`AES_IDX_STATE, v);
    chk(v, CT);
    rd(`AES_IDX_STATUS, 8'h00);
    chk(128'(irq), 128'h0);
    host.fetch(`AES_IDX_KEY, v);
    chk(v, RK10);
    $display("test encrypt done");
  endtask
  task automatic t_decrypt();
    int           n;
    logic [127:0] v;
    wr(`AES_IDX_INTCTRL, 8'h00);
    wr(`AES_IDX_CTRL, 8'h10);
    host.load(`AES_IDX_KEY, RK10);
    host.load(`AES_IDX_STATE, CT);
    wr(`AES_IDX_CTRL, 8'h90);
    wait_done(n);
    chk(128'(n), 128'd375);
    chk(128'(irq), 128'h0);
    @(posedge pclk);
    host.fetch(`AES_IDX_STATE, v);
    chk(v, PT);
    host.fetch(`AES_IDX_KEY, v);
    chk(v, KEY0);
    $display("test decrypt done");
  endtask
  task automatic t_errors();
    int n;
    wr(`AES_IDX_CTRL, 8'h00);
    wr(`AES_IDX_KEY, 8'h5a);
    wr(`AES_IDX_CTRL, 8'h80);
    rd(`AES_IDX_STATUS, 8'h80);
    rd(`AES_IDX_CTRL, 8'h00);
    wr(`AES_IDX_STATUS, 8'h80);
    rd(`AES_IDX_STATUS, 8'h00);
    n = dma_count;
    wr(`AES_IDX_CTRL, 8'h80);
    rd(`AES_IDX_CTRL, 8'h80);
    rd(`AES_IDX_STATUS, 8'h80);
    rd(`AES_IDX_CTRL, 8'h00);
    // longer than a full run, so an aborted run would have finished
    repeat (400) @(posedge pclk);
    chk(128'(dma_count), 128'(n));
    wr(`AES_IDX_STATUS, 8'h80);
    rd(`AES_IDX_STATUS, 8'h00);
    $display("test errors done");
  endtask
  task automatic t_auto();
    int           n;
    logic [127:0] v;
    wr(`AES_IDX_CTRL, 8'h40);
    host.load(`AES_IDX_KEY, KEY0);
    host.load(`AES_IDX_STATE, PT);
    wait_done(n);
    chk(128'(n), 128'd375);
    @(posedge pclk);
    wr(`AES_IDX_STATUS, 8'h01);
    rd(`AES_IDX_STATUS, 8'h00);
    host.fetch(`AES_IDX_STATE, v);
    chk(v, CT);
    $display("test auto done");
  endtask
  task automatic t_xor_reset();
    logic [127:0] v;
    logic [127:0] x;
    x = CT ^ PT ^ KEY0;
    wr(`AES_IDX_CTRL, 8'h04);
    host.load(`AES_IDX_STATE, PT);
    host.load(`AES_IDX_STATE, KEY0);
    wr(`AES_IDX_STATE, 8'h00);
    rd(`AES_IDX_STATE, x[119:112]);
    wr(`AES_IDX_CTRL, 8'h00);
    host.fetch(`AES_IDX_STATE, v);
    chk(v, x);
    wr(`AES_IDX_INTCTRL, 8'h03);
    wr(`AES_IDX_CTRL, 8'h24);
    rd(`AES_IDX_CTRL, 8'h00);
    rd(`AES_IDX_INTCTRL, 8'h00);
    chk(128'(lvl), 128'h0);
    host.fetch(`AES_IDX_STATE, v);
    chk(v, 128'h0);
    $display("test xor and reset done");
  endtask

  initial begin
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_encrypt();
    t_decrypt();
    t_errors();
    t_auto();
    t_xor_reset();
    stop_test();
  end
endmodule
